// ==== rtl/bitops_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
// complement, compare and single bit datapath slice
module bitops_unit
  import bitops_pkg::*;
#(
  // datapath width; masks, ports and the subtractor are byte wide
  parameter int DATA_WIDTH = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // operation request from the sequencer
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [2:0] bit_index,
  input wire logic [1:0] io_select,
  // data memory read side
  input wire logic [7:0] mem_rdata,
  // data memory write side
  output logic mem_we,
  output logic [7:0] mem_wdata,
  // port pins
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  input wire logic [7:0] port_a_dir,
  input wire logic [7:0] port_b_dir,
  // architectural state
  output logic [7:0] accumulator,
  output logic [7:0] port_a_data,
  output logic [7:0] port_b_data,
  output logic zero_flag,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic overflow_flag
);
  // state registers
  logic [7:0] acc_reg, acc_next;
  logic [3:0] flags_reg, flags_next;
  logic [7:0] pa_reg, pa_next;
  logic [7:0] pb_reg, pb_next;
  logic mem_we_reg, mem_we_next;
  logic [7:0] mem_wdata_reg, mem_wdata_next;

  // elaboration check: the three bit index and the flag layout only fit a byte
  if (DATA_WIDTH != 8)
  begin : g_width_check
    $error("bitops_unit only serves an eight bit datapath");
  end

  // one hot mask from the three bit index
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = ONE_BYTE << idx;
  endfunction

  // two's complement of a byte, wraps modulo 256
  function automatic logic [7:0] negate(input logic [7:0] v);
    negate = 8'(~v + ONE_BYTE);
  endfunction

  // decode
  wire op_type op;
  wire logic [7:0] mask;
  wire logic is_cmp_am;
  wire logic is_cmp_ma;
  assign op = op_valid ? op_type'(op_code) : OP_NONE;
  assign mask = bit_mask(bit_index);
  assign is_cmp_am = (op == OP_COMP_AM);
  assign is_cmp_ma = (op == OP_COMP_MA);

  // compare operand order chosen per instruction
  wire logic [7:0] cmp_min;
  wire logic [7:0] cmp_sub;
  // the difference itself is never stored; compares only move flags
  wire logic cmp_zero, cmp_borrow, cmp_half, cmp_ovf;
  assign cmp_min = is_cmp_ma ? mem_rdata : acc_reg;
  assign cmp_sub = is_cmp_ma ? acc_reg : mem_rdata;

  sub_flags u_sub (
    .minuend(cmp_min),
    .subtrahend(cmp_sub),
    .diff(),
    .zero(cmp_zero),
    .borrow(cmp_borrow),
    .half_borrow(cmp_half),
    .overflow(cmp_ovf)
  );

  // unary results
  wire logic [7:0] not_acc;
  wire logic [7:0] not_mem;
  wire logic [7:0] neg_acc;
  wire logic [7:0] neg_mem;
  assign not_acc = ~acc_reg;
  assign not_mem = ~mem_rdata;
  assign neg_acc = negate(acc_reg);
  assign neg_mem = negate(mem_rdata);

  // selected io register and its bit for swap
  wire logic [7:0] io_cur;
  wire logic [7:0] io_dir;
  wire logic [7:0] io_pins;
  wire logic io_is_output;
  wire logic io_in_bit;
  wire logic sel_port_a;
  wire logic sel_port_b;
  wire logic sel_flags;
  // the spare select code behaves as port a for reads and writes alike
  assign sel_port_b = (io_select == IO_SEL_PORT_B);
  assign sel_flags = (io_select == IO_SEL_FLAGS);
  assign sel_port_a = !sel_port_b && !sel_flags;
  assign io_cur = sel_port_b ? pb_reg :
                  sel_flags ? {4'h0, flags_reg} : pa_reg;
  // flag bits have no pin, so they look like outputs and a swap reads the latch
  assign io_dir = sel_port_b ? port_b_dir : sel_flags ? 8'hff : port_a_dir;
  assign io_pins = sel_port_b ? port_b_pins : port_a_pins;
  // direction bit high means the pin drives out
  assign io_is_output = |(io_dir & mask);
  // input pins give the sampled level, else the latch
  assign io_in_bit = io_is_output ? |(io_cur & mask) : |(io_pins & mask);

  // io bit modified by clear, set or swap
  wire logic [7:0] io_new;
  wire logic io_write;
  wire logic carry_prior;
  assign carry_prior = flags_reg[FLAG_CARRY_POS];
  assign io_new = (op == OP_IO_CLR) ? (io_cur & ~mask) :
                  (op == OP_IO_SET) ? (io_cur | mask) :
                  (carry_prior ? (io_cur | mask) : (io_cur & ~mask));
  assign io_write = (op == OP_IO_CLR) || (op == OP_IO_SET) || (op == OP_SWAPC);

  // next state for accumulator and flags
  always_comb
  begin
    acc_next = acc_reg;
    flags_next = flags_reg;
    mem_we_next = 1'b0;
    mem_wdata_next = mem_wdata_reg;
    case (op)
      OP_NOT_ACC:
      begin
        acc_next = not_acc;
        flags_next[FLAG_ZERO_POS] = (not_acc == 8'h00);
      end
      OP_NOT_MEM:
      begin
        mem_we_next = 1'b1;
        mem_wdata_next = not_mem;
        flags_next[FLAG_ZERO_POS] = (not_mem == 8'h00);
      end
      OP_NEG_ACC:
      begin
        acc_next = neg_acc;
        flags_next[FLAG_ZERO_POS] = (neg_acc == 8'h00);
      end
      OP_NEG_MEM:
      begin
        mem_we_next = 1'b1;
        mem_wdata_next = neg_mem;
        flags_next[FLAG_ZERO_POS] = (neg_mem == 8'h00);
      end
      OP_COMP_AM, OP_COMP_MA:
      begin
        // flags only; neither operand written
        flags_next[FLAG_ZERO_POS] = cmp_zero;
        flags_next[FLAG_CARRY_POS] = cmp_borrow;
        flags_next[FLAG_HALF_POS] = cmp_half;
        flags_next[FLAG_OVF_POS] = cmp_ovf;
      end
      OP_SWAPC:
      begin
        // only the carry moves among the flags
        flags_next[FLAG_CARRY_POS] = io_in_bit;
      end
      OP_IO_CLR, OP_IO_SET:
      begin
        // flag register reached as an io register takes the indexed flag bit directly
        if (io_select == IO_SEL_FLAGS)
        begin
          flags_next = io_new[3:0];
        end
      end
      OP_MEM_CLR:
      begin
        mem_we_next = 1'b1;
        mem_wdata_next = mem_rdata & ~mask;
      end
      OP_MEM_SET:
      begin
        mem_we_next = 1'b1;
        mem_wdata_next = mem_rdata | mask;
      end
      default:
      begin
        acc_next = acc_reg;
      end
    endcase
  end

  // port latch next values; a swap writes the latch even on input bits,
  // so the old carry is already waiting there once the pin turns to output
  assign pa_next = (io_write && sel_port_a) ? io_new : pa_reg;
  assign pb_next = (io_write && sel_port_b) ? io_new : pb_reg;

  // state update
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      acc_reg <= ACC_RESET;
      flags_reg <= FLAG_RESET;
      pa_reg <= PORT_RESET;
      pb_reg <= PORT_RESET;
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= 8'h00;
    end
    else
    begin
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      pa_reg <= pa_next;
      pb_reg <= pb_next;
      mem_we_reg <= mem_we_next;
      mem_wdata_reg <= mem_wdata_next;
    end
  end

  // outputs straight from flip-flops
  assign accumulator = acc_reg;
  assign port_a_data = pa_reg;
  assign port_b_data = pb_reg;
  assign zero_flag = flags_reg[FLAG_ZERO_POS];
  assign carry_flag = flags_reg[FLAG_CARRY_POS];
  assign half_carry_flag = flags_reg[FLAG_HALF_POS];
  assign overflow_flag = flags_reg[FLAG_OVF_POS];
  assign mem_we = mem_we_reg;
  assign mem_wdata = mem_wdata_reg;

  // checks beside the logic
  chk_not_acc_value: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_NOT_ACC |=> accumulator == ~$past(accumulator)
      && carry_flag == $past(carry_flag) && overflow_flag == $past(overflow_flag))
    else $error("complement of accumulator wrong");
  chk_not_mem_write: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_NOT_MEM |=> mem_we && mem_wdata == ~$past(mem_rdata)
      && zero_flag == (mem_wdata == 8'h00))
    else $error("memory complement wrong");
  chk_neg_acc_value: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_NEG_ACC |=> accumulator == 8'(8'h00 - $past(accumulator))
      && half_carry_flag == $past(half_carry_flag))
    else $error("negate of accumulator wrong");
  chk_neg_mem_write: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_NEG_MEM |=> mem_we && mem_wdata == 8'(8'h00 - $past(mem_rdata)))
    else $error("memory negate wrong");
  chk_cmp_am_flags: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_COMP_AM |=> !mem_we && accumulator == $past(accumulator)
      && carry_flag == ($past(accumulator) < $past(mem_rdata)))
    else $error("compare acc minus mem wrong");
  chk_cmp_ma_flags: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_COMP_MA |=> !mem_we && accumulator == $past(accumulator)
      && carry_flag == ($past(mem_rdata) < $past(accumulator)))
    else $error("compare mem minus acc wrong");
  chk_cmp_equal_zero: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && (op_code == OP_COMP_AM || op_code == OP_COMP_MA) && acc_reg == mem_rdata
      |=> zero_flag && !carry_flag)
    else $error("equal compare must set zero");
  chk_io_clear_bit: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_IO_CLR && io_select == IO_SEL_PORT_A
      |=> port_a_data == ($past(port_a_data) & ~$past(mask)) && carry_flag == $past(carry_flag))
    else $error("io bit clear wrong");
  chk_io_set_bit: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_IO_SET && io_select == IO_SEL_PORT_B
      |=> port_b_data == ($past(port_b_data) | $past(mask)))
    else $error("io bit set wrong");
  chk_swap_out_bit: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_SWAPC && io_select == IO_SEL_PORT_A && io_is_output
      |=> port_a_data[$past(bit_index)] == $past(carry_flag))
    else $error("swap did not send carry out");
  chk_swap_in_carry: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_SWAPC && io_select == IO_SEL_PORT_B && !io_is_output
      |=> carry_flag == $past(port_b_pins[bit_index]) && zero_flag == $past(zero_flag))
    else $error("swap did not load pin into carry");
  chk_mem_bit_ops: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_MEM_CLR |=> mem_we && mem_wdata == ($past(mem_rdata) & ~$past(mask))
      && $stable(flags_reg))
    else $error("memory bit clear wrong");
  chk_flag_carry_pos: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_IO_SET && io_select == IO_SEL_FLAGS && bit_index == 3'd1
      |=> carry_flag)
    else $error("carry not at flag bit one");
  // carry is cleared through flag bit one as well
  chk_flag_carry_clr: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_IO_CLR && io_select == IO_SEL_FLAGS && bit_index == 3'd1
      |=> !carry_flag && zero_flag == $past(zero_flag) && overflow_flag == $past(overflow_flag))
    else $error("carry not cleared through flag bit one");
  // zero follows the inverted accumulator, half carry is left alone
  chk_not_acc_zero: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_NOT_ACC
      |=> zero_flag == (accumulator == 8'h00) && half_carry_flag == $past(half_carry_flag))
    else $error("complement of accumulator moved the wrong flags");
  // memory complement must not touch the accumulator or carry
  chk_not_mem_keep: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_NOT_MEM
      |=> accumulator == $past(accumulator) && carry_flag == $past(carry_flag))
    else $error("memory complement changed other state");
  // negate moves zero only
  chk_neg_acc_flags: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_NEG_ACC |=> zero_flag == (accumulator == 8'h00)
      && carry_flag == $past(carry_flag) && overflow_flag == $past(overflow_flag))
    else $error("negate of accumulator moved the wrong flags");
  // memory negate sets zero from the written byte and keeps the accumulator
  chk_neg_mem_flags: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_NEG_MEM |=> zero_flag == (mem_wdata == 8'h00)
      && accumulator == $past(accumulator) && half_carry_flag == $past(half_carry_flag))
    else $error("memory negate moved the wrong state");
  // zero and half borrow of accumulator minus memory
  chk_cmp_am_zero: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_COMP_AM |=> zero_flag == ($past(accumulator) == $past(mem_rdata))
      && half_carry_flag == ($past(accumulator[3:0]) < $past(mem_rdata[3:0])))
    else $error("compare acc minus mem zero or half wrong");
  // zero and half borrow of memory minus accumulator
  chk_cmp_ma_zero: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_COMP_MA |=> zero_flag == ($past(mem_rdata) == $past(accumulator))
      && half_carry_flag == ($past(mem_rdata[3:0]) < $past(accumulator[3:0])))
    else $error("compare mem minus acc zero or half wrong");
  // operands of equal sign can never overflow a subtraction
  chk_cmp_ovf_sign: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && (op_code == OP_COMP_AM || op_code == OP_COMP_MA) && acc_reg[7] == mem_rdata[7]
      |=> !overflow_flag)
    else $error("compare overflow on equal signs");
  // a smaller minuend borrows and cannot be zero
  chk_cmp_less_borrow: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_COMP_AM && acc_reg < mem_rdata
      |=> carry_flag && !zero_flag)
    else $error("compare borrow missing");
  // an output bit hands its latch value to carry, other flags stay
  chk_swap_out_carry: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_SWAPC && io_select == IO_SEL_PORT_A && io_is_output
      |=> carry_flag == $past(port_a_data[bit_index]) && half_carry_flag == $past(half_carry_flag))
    else $error("swap did not return latch bit to carry");
  // the spare select code swaps with port a
  chk_swap_spare_sel: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_SWAPC && io_select == 2'h3
      |=> port_a_data[$past(bit_index)] == $past(carry_flag))
    else $error("swap on spare select missed port a");
  // a low direction bit makes the pin the source of carry
  chk_dir_low_input: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_SWAPC && io_select == IO_SEL_PORT_A && !port_a_dir[bit_index]
      |=> carry_flag == $past(port_a_pins[bit_index]))
    else $error("input direction not honoured");
  // memory bit set writes one bit and no flag
  chk_mem_bit_set: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_MEM_SET |=> mem_we && mem_wdata == ($past(mem_rdata) | $past(mask))
      && $stable(flags_reg))
    else $error("memory bit set wrong");
  // io set on port a leaves flags and port b alone
  chk_io_set_keep: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_IO_SET && io_select == IO_SEL_PORT_A
      |=> port_a_data == ($past(port_a_data) | $past(mask)) && $stable(flags_reg) && $stable(port_b_data))
    else $error("io bit set on port a wrong");
  // io clear on port b leaves flags and port a alone
  chk_io_clear_keep: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && op_code == OP_IO_CLR && io_select == IO_SEL_PORT_B
      |=> port_b_data == ($past(port_b_data) & ~$past(mask)) && $stable(flags_reg) && $stable(port_a_data))
    else $error("io bit clear on port b wrong");
  // the bit index picks exactly one of eight positions
  chk_mask_one_hot: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot(mask) && mask[bit_index])
    else $error("bit mask not one hot");
  // no memory write without a memory op
  chk_mem_we_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !op_valid |=> !mem_we)
    else $error("memory write without an op");
endmodule
`default_nettype wire

// ==== rtl/bitops_pkg.sv ====
// Notes on behaviour
// - accumulator complement inverts, updates zero only
// - memory complement writes inverse, zero only
// - accumulator negate: inverse plus one, zero only
// - memory negate writes two's complement, zero only
// - compare acc minus mem sets four flags
// - compare mem minus acc sets four flags
// - equal operands set zero flag
// - smaller minuend sets carry as borrow
// - io bit clear drives bit low only
// - io bit set drives bit high only
// - carry swap exchanges carry with port bit
// - output bit receives prior carry on swap
// - input bit loads pin level into carry
// - memory bit clear clears bit only
// - memory bit set sets bit only
// - direction bit one means output pin
package bitops_pkg;
  // flag register layout
  localparam int FLAG_ZERO_POS = 0;
  localparam int FLAG_CARRY_POS = 1;
  localparam int FLAG_HALF_POS = 2;
  localparam int FLAG_OVF_POS = 3;
  localparam logic [3:0] FLAG_RESET = 4'h0;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  // io register selects
  localparam logic [1:0] IO_SEL_PORT_A = 2'h0;
  localparam logic [1:0] IO_SEL_PORT_B = 2'h1;
  localparam logic [1:0] IO_SEL_FLAGS = 2'h2;
  // operations carried out by this slice
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_NOT_ACC = 4'b0001,
    OP_NOT_MEM = 4'b0010,
    OP_NEG_ACC = 4'b0011,
    OP_NEG_MEM = 4'b0100,
    OP_COMP_AM = 4'b0101,
    OP_COMP_MA = 4'b0110,
    OP_IO_CLR = 4'b0111,
    OP_IO_SET = 4'b1000,
    OP_SWAPC = 4'b1001,
    OP_MEM_CLR = 4'b1010,
    OP_MEM_SET = 4'b1011
  } op_type;
endpackage

// ==== rtl/sub_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
// subtractor with zero, borrow, half borrow and overflow
module sub_flags
  import bitops_pkg::*;
(
  // operands
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  // result
  output logic [7:0] diff,
  output logic zero,
  output logic borrow,
  output logic half_borrow,
  output logic overflow
);
  // nine bit difference keeps the borrow out
  wire logic [8:0] wide_diff;
  wire logic [4:0] low_diff;

  assign wide_diff = {1'b0, minuend} - {1'b0, subtrahend};
  assign low_diff = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
  assign diff = wide_diff[7:0];
  assign zero = (wide_diff[7:0] == 8'h00);
  assign borrow = wide_diff[8];
  assign half_borrow = low_diff[4];
  // signed overflow: operand signs differ and result sign follows subtrahend
  assign overflow = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ wide_diff[7]);
endmodule
`default_nettype wire

// ==== verif/tb_bitops_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_bitops_unit
  import bitops_pkg::*;
;
  // architectural state as the bench expects it
  typedef struct packed
  {
    logic [7:0] acc;
    logic [7:0] pa;
    logic [7:0] pb;
    logic z;
    logic c;
    logic h;
    logic v;
    logic we;
    logic [7:0] wd;
  } state_type;

  // clock, reset and request
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  logic [3:0] op_code = 4'h0;
  logic [2:0] bit_index = 3'h0;
  logic [1:0] io_select = 2'h0;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] port_a_pins = 8'h00;
  logic [7:0] port_b_pins = 8'h00;
  logic [7:0] port_a_dir = 8'h00;
  logic [7:0] port_b_dir = 8'h00;
  // design outputs
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] accumulator;
  logic [7:0] port_a_data;
  logic [7:0] port_b_data;
  logic zero_flag;
  logic carry_flag;
  logic half_carry_flag;
  logic overflow_flag;
  // bench bookkeeping
  int mismatches = 0;
  int total_checks = 0;
  integer seed = 32'h7f5f;
  state_type st; // state after every op driven so far
  state_type chk; // state the design should show now
  int i;

  bitops_unit u_dut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code), .bit_index(bit_index),
    .io_select(io_select), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .port_a_pins(port_a_pins), .port_b_pins(port_b_pins), .port_a_dir(port_a_dir), .port_b_dir(port_b_dir),
    .accumulator(accumulator), .port_a_data(port_a_data), .port_b_data(port_b_data), .zero_flag(zero_flag),
    .carry_flag(carry_flag), .half_carry_flag(half_carry_flag), .overflow_flag(overflow_flag));

  // free running 40 mhz clock
  always #12.5 clk = ~clk;

  // reference model of one taken op; pins and dir are those of the selected port
  function automatic state_type apply(state_type s, logic vld, logic [3:0] code, logic [2:0] idx, logic [1:0] sel,
    logic [7:0] m, logic [7:0] pins, logic [7:0] dir);
    state_type r;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] d;
    logic [7:0] lat;
    logic val;
    r = s;
    r.we = 1'b0;
    val = (code == OP_IO_SET) || (code == OP_MEM_SET);
    a = (code == OP_COMP_AM) ? s.acc : m;
    b = (code == OP_COMP_AM) ? m : s.acc;
    d = a - b;
    lat = (sel == IO_SEL_PORT_B) ? s.pb : s.pa;
    // idle or unknown codes leave everything alone
    if (!vld)
      return r;
    case (code)
      OP_NOT_ACC: r.acc = ~s.acc;
      OP_NEG_ACC: r.acc = 8'h00 - s.acc;
      OP_NOT_MEM: r.wd = ~m;
      OP_NEG_MEM: r.wd = 8'h00 - m;
      OP_COMP_AM, OP_COMP_MA:
      begin
        r.z = (d == 8'h00);
        r.c = (a < b);
        r.h = (a[3:0] < b[3:0]);
        r.v = (a[7] != b[7]) && (d[7] != a[7]);
      end
      OP_IO_CLR, OP_IO_SET:
      begin
        // flag register bits: zero 0, carry 1, half 2, overflow 3
        if (sel == IO_SEL_FLAGS)
        begin
          r.z = (idx == 3'h0) ? val : s.z;
          r.c = (idx == 3'h1) ? val : s.c;
          r.h = (idx == 3'h2) ? val : s.h;
          r.v = (idx == 3'h3) ? val : s.v;
        end
        else if (sel == IO_SEL_PORT_B)
          r.pb[idx] = val;
        else
          r.pa[idx] = val;
      end
      OP_SWAPC:
      begin
        // output bit hands back its latch, input bit hands back the pin
        r.c = dir[idx] ? lat[idx] : pins[idx];
        if (sel == IO_SEL_PORT_B)
          r.pb[idx] = s.c;
        else
          r.pa[idx] = s.c;
      end
      OP_MEM_CLR, OP_MEM_SET:
      begin
        r.wd = m;
        r.wd[idx] = val;
        r.we = 1'b1;
      end
      default: ;
    endcase
    if ((code == OP_NOT_ACC) || (code == OP_NEG_ACC))
      r.z = (r.acc == 8'h00);
    if ((code == OP_NOT_MEM) || (code == OP_NEG_MEM))
    begin
      r.we = 1'b1;
      r.z = (r.wd == 8'h00);
    end
    return r;
  endfunction

  // one compare, counted
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] seen);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // all outputs against the model, sampled mid cycle
  task automatic compare_all();
    check8("accumulator", chk.acc, accumulator);
    check8("port_a_data", chk.pa, port_a_data);
    check8("port_b_data", chk.pb, port_b_data);
    check8("zero_flag", {7'h00, chk.z}, {7'h00, zero_flag});
    check8("carry_flag", {7'h00, chk.c}, {7'h00, carry_flag});
    check8("half_carry_flag", {7'h00, chk.h}, {7'h00, half_carry_flag});
    check8("overflow_flag", {7'h00, chk.v}, {7'h00, overflow_flag});
    check8("mem_we", {7'h00, chk.we}, {7'h00, mem_we});
    check8("mem_wdata", chk.wd, mem_wdata);
  endtask

  // drive one op back to back; check what the previous edge took
  task automatic run_op(input logic vld, input logic [3:0] code, input logic [2:0] idx, input logic [1:0] sel,
    input logic [7:0] m, input logic [7:0] dirs);
    logic [7:0] pa_p;
    logic [7:0] pb_p;
    pa_p = 8'($random(seed));
    pb_p = 8'($random(seed));
    @(posedge clk);
    op_valid <= vld;
    op_code <= code;
    bit_index <= idx;
    io_select <= sel;
    mem_rdata <= m;
    port_a_pins <= pa_p;
    port_b_pins <= pb_p;
    port_a_dir <= dirs;
    port_b_dir <= ~dirs;
    chk = st;
    st = apply(st, vld, code, idx, sel, m, (sel == IO_SEL_PORT_B) ? pb_p : pa_p, (sel == IO_SEL_PORT_B) ? ~dirs : dirs);
    @(negedge clk);
    compare_all();
  endtask

  // synchronous reset held for three edges
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    op_valid <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    st = '0;
    chk = st;
    @(negedge clk);
    compare_all();
  endtask

  // verdict and end of run
  task automatic complete_run();
    if ((mismatches == 0) && (total_checks > 0))
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // main sequence: corner cases, then random traffic, a reset in the middle
  initial
  begin
    do_reset();
    run_op(1'b1, OP_NOT_MEM, 3'h0, 2'h0, 8'h38, 8'h00);
    run_op(1'b1, OP_COMP_AM, 3'h0, 2'h0, 8'h00, 8'h00);
    run_op(1'b1, OP_NEG_ACC, 3'h0, 2'h0, 8'h00, 8'h00);
    run_op(1'b1, OP_NOT_ACC, 3'h0, 2'h0, 8'h38, 8'h00);
    run_op(1'b1, OP_COMP_MA, 3'h0, 2'h0, 8'h00, 8'h00);
    run_op(1'b1, OP_NEG_MEM, 3'h0, 2'h0, 8'h38, 8'h00);
    run_op(1'b1, OP_IO_SET, 3'h1, IO_SEL_FLAGS, 8'h00, 8'hff);
    run_op(1'b1, OP_SWAPC, 3'h0, IO_SEL_PORT_A, 8'h00, 8'hff);
    run_op(1'b1, OP_IO_CLR, 3'h1, IO_SEL_FLAGS, 8'h00, 8'hff);
    run_op(1'b1, OP_SWAPC, 3'h0, IO_SEL_PORT_A, 8'h00, 8'hff);
    run_op(1'b1, OP_SWAPC, 3'h7, IO_SEL_PORT_B, 8'h00, 8'hff);
    run_op(1'b1, OP_MEM_SET, 3'h7, 2'h0, 8'h00, 8'h00);
    run_op(1'b1, OP_MEM_CLR, 3'h0, 2'h0, 8'hff, 8'h00);
    run_op(1'b0, OP_NOT_ACC, 3'h0, 2'h0, 8'h00, 8'h00);
    run_op(1'b1, 4'hf, 3'h0, 2'h0, 8'h00, 8'h00);
    for (i = 0; i < 2000; i++)
    begin
      logic [31:0] rnd;
      logic [1:0] sel;
      logic [2:0] idx;
      rnd = $random(seed);
      sel = rnd[5:4];
      idx = rnd[8:6];
      // flag register is four bits wide and swap on it is left alone
      if (sel == IO_SEL_FLAGS)
        idx[2] = 1'b0;
      if ((sel == IO_SEL_FLAGS) && (rnd[3:0] == OP_SWAPC))
        sel = IO_SEL_PORT_A;
      run_op(rnd[11:9] != 3'h0, rnd[3:0], idx, sel, rnd[19:12], rnd[27:20]);
      if (i == 1000)
        do_reset();
    end
    run_op(1'b0, OP_NONE, 3'h0, 2'h0, 8'h00, 8'h00);
    complete_run();
  end

  // hang guard, well beyond the expected run length
  initial
  begin
    #200000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
